// ---- design/xmb_consts.svh ----
// constants of the external memory bus: offsets, fields, codes, reset values
`ifndef XMB_CONSTS_SVH
`define XMB_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define XMB_OFF_CONFIG   8'h00
`define XMB_OFF_CONTROL  8'h04
`define XMB_OFF_STATUS   8'h08
`define XMB_OFF_PORTOUT  8'h0c
`define XMB_OFF_PORTDIR  8'h10
`define XMB_OFF_PORTIN   8'h14

// ****************************************
// register fields and reset values
// ****************************************
`define XMB_CTRL_DISABLE_BIT 0
`define XMB_CTRL_RESET       1'b0
`define XMB_STAT_BUSY_BIT    0
`define XMB_STAT_LOADED_BIT  1
`define XMB_PORT_RESET       32'h0000_0000

// ****************************************
// address width codes
// ****************************************
`define XMB_ABW_20   2'b00
`define XMB_ABW_16   2'b01
`define XMB_ABW_12   2'b10
`define XMB_ABW_MCU  2'b11

// ****************************************
// control port bit positions
// ****************************************
`define XMB_CTL_ALE  0
`define XMB_CTL_OE   1
`define XMB_CTL_WRL  2
`define XMB_CTL_WRH  3
`define XMB_CTL_BA0  4
`define XMB_CTL_CE   5
`define XMB_CTL_LB   6
`define XMB_CTL_UB   7
`define XMB_CTL_IDLE 8'hee

// ****************************************
// axi responses
// ****************************************
`define XMB_RESP_OKAY   2'b00
`define XMB_RESP_DECERR 2'b11

`endif

// ---- design/xmb_pkg.sv ----
// types shared by the external memory bus design
package xmb_pkg;

    // one byte per port: control, upper address, high data, low data
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] upper;
        logic [7:0] high;
        logic [7:0] low;
    } xmb_port_t;

    // nonvolatile bus configuration word
    typedef struct packed {
        logic       dataWide;
        logic [1:0] addrWidth;
        logic       shiftEn;
    } xmb_cfg_t;

    // core request towards the bus
    typedef struct packed {
        logic        write;
        logic [20:0] addr;
        logic [15:0] wdata;
        logic [1:0]  byteEn;
    } xmb_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_LATCH = 3'b010,
        ST_DATA  = 3'b011,
        ST_DONE  = 3'b100,
        ST_FAIL  = 3'b101
    } xmb_state_t;

endpackage

// ---- design/xmb_external_memory_bus.sv ----
// external memory bus controller with pin multiplexing and axi4-lite registers
`timescale 1ns/10ps
`include "xmb_consts.svh"

module xmb_external_memory_bus #(
    parameter logic [20:0] ONCHIP_BYTES  = 21'h010000,
    parameter int          STROBE_CYCLES = 2
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    // nonvolatile configuration word, sampled once after reset
    input  wire xmb_pkg::xmb_cfg_t cfgWord,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire xmb_pkg::xmb_req_t req,
    output logic                   rspValid,
    output logic                   rspError,
    output logic [15:0]            rspData,
    input  wire xmb_pkg::xmb_port_t pinIn,
    output xmb_pkg::xmb_port_t     pinOut,
    output xmb_pkg::xmb_port_t     pinOe,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ****************************************
    // functions
    // ****************************************
    // pins owned by the bus for a given configuration
    function automatic xmb_pkg::xmb_port_t bus_mask(input xmb_pkg::xmb_cfg_t c, input logic dis);
        xmb_pkg::xmb_port_t m;
        m = '0;
        if (!dis && c.addrWidth != `XMB_ABW_MCU) begin
            m.ctl = 8'hff;
            m.low = 8'hff;
            // upper data nibble lost at 12-bit
            if (c.addrWidth == `XMB_ABW_12) begin
                m.high = 8'h0f;
            end else begin
                m.high = 8'hff;
            end
            if (c.addrWidth == `XMB_ABW_20) begin
                m.upper = 8'h0f;
            end
        end
        return m;
    endfunction
    // byte-lane merge under write strobes, shared by both port registers
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) o[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
        return o;
    endfunction

    // ****************************************
    // configuration capture
    // ****************************************
    xmb_pkg::xmb_cfg_t cfg;
    logic              cfgLoaded;

    // loaded once at reset release, no software path
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg       <= '{dataWide: 1'b1, addrWidth: `XMB_ABW_MCU, shiftEn: 1'b0};
            cfgLoaded <= 1'b0;
        end else if (!cfgLoaded) begin
            cfg       <= cfgWord;
            cfgLoaded <= 1'b1;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    logic        busDisable;
    logic [31:0] portOut;
    logic [31:0] portDir;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    xmb_pkg::xmb_state_t state;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // address and data are taken in either order, then answered together
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= 8'h00;
            wData  <= 32'h0000_0000;
            wStrb  <= 4'h0;
        end else begin
            awHeld <= !(awHeld && wHeld) && (awHeld || (s_axi_awvalid && s_axi_awready));
            wHeld  <= !(awHeld && wHeld) && (wHeld || (s_axi_wvalid && s_axi_wready));
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
        end
    end
    // register writes and write response
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busDisable   <= `XMB_CTRL_RESET;
            portOut      <= `XMB_PORT_RESET;
            portDir      <= `XMB_PORT_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `XMB_RESP_OKAY;
        end else if (awHeld && wHeld) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `XMB_RESP_OKAY;
            unique case ({awAddr[7:2], 2'b00})
                `XMB_OFF_CONTROL: begin
                    if (wStrb[0]) begin
                        busDisable <= wData[`XMB_CTRL_DISABLE_BIT];
                    end
                end
                `XMB_OFF_PORTOUT: portOut <= merge(portOut, wData, wStrb);
                `XMB_OFF_PORTDIR: portDir <= merge(portDir, wData, wStrb);
                // config word is read only: writes are accepted and dropped
                `XMB_OFF_CONFIG, `XMB_OFF_STATUS, `XMB_OFF_PORTIN: s_axi_bresp <= `XMB_RESP_OKAY;
                default: s_axi_bresp <= `XMB_RESP_DECERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // register reads, answered one cycle after the address
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `XMB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `XMB_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `XMB_OFF_CONFIG:  s_axi_rdata <= {28'h0000000, cfg};
                `XMB_OFF_CONTROL: s_axi_rdata <= {31'h00000000, busDisable};
                `XMB_OFF_STATUS:  s_axi_rdata <= {30'h00000000, cfgLoaded,
                                                  state != xmb_pkg::ST_IDLE};
                `XMB_OFF_PORTOUT: s_axi_rdata <= portOut;
                `XMB_OFF_PORTDIR: s_axi_rdata <= portDir;
                `XMB_OFF_PORTIN:  s_axi_rdata <= pinIn;
                default:          s_axi_rresp <= `XMB_RESP_DECERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    logic        busActive;
    logic [20:0] cycAddr;
    logic        cycWrite;
    logic [15:0] cycWdata;
    logic [1:0]  cycByteEn;
    logic        secondByte;
    logic [7:0]  strobeCnt;
    logic [15:0] readData;
    logic [15:0] busAd;
    logic [15:0] busAdOe;
    logic [3:0]  busUpper;
    logic [7:0]  busCtl;
    logic [19:0] lineAddr;

    // mcu code or disable: no cycles
    assign busActive = cfgLoaded && !busDisable && cfg.addrWidth != `XMB_ABW_MCU;
    assign reqReady  = state == xmb_pkg::ST_IDLE;
    // line address is byte address without its lsb
    assign lineAddr  = cycAddr[20:1];

    // state walk: address phase, latch, strobe, finish
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state      <= xmb_pkg::ST_IDLE;
            cycAddr    <= 21'h000000;
            cycWrite   <= 1'b0;
            cycWdata   <= 16'h0000;
            cycByteEn  <= 2'b00;
            secondByte <= 1'b0;
            strobeCnt  <= 8'h00;
        end else begin
            unique case (state)
                xmb_pkg::ST_IDLE: begin
                    if (reqValid && !busActive) begin
                        state <= xmb_pkg::ST_FAIL;
                    end else if (reqValid) begin
                        state     <= xmb_pkg::ST_ADDR;
                        cycWrite  <= req.write;
                        cycWdata  <= req.wdata;
                        cycByteEn <= req.byteEn;
                        // counter as is, or shifted past on-chip memory
                        cycAddr <= {req.addr[20:1] -
                                    (cfg.shiftEn ? ONCHIP_BYTES[20:1] : 20'h00000),
                                    !cfg.dataWide && req.byteEn == 2'b10};
                        secondByte <= !cfg.dataWide && req.byteEn == 2'b11;
                    end
                end
                xmb_pkg::ST_ADDR:  state <= xmb_pkg::ST_LATCH;
                xmb_pkg::ST_LATCH: begin
                    state     <= xmb_pkg::ST_DATA;
                    strobeCnt <= 8'(STROBE_CYCLES - 1);
                end
                xmb_pkg::ST_DATA: begin
                    if (strobeCnt != 8'h00) begin
                        strobeCnt <= strobeCnt - 8'h01;
                    end else if (secondByte) begin
                        // 8-bit width: odd byte of the word in a second cycle
                        state      <= xmb_pkg::ST_ADDR;
                        secondByte <= 1'b0;
                        cycAddr[0] <= 1'b1;
                    end else begin
                        state <= xmb_pkg::ST_DONE;
                    end
                end
                xmb_pkg::ST_DONE, xmb_pkg::ST_FAIL: state <= xmb_pkg::ST_IDLE;
                default:          state <= xmb_pkg::ST_IDLE;
            endcase
        end
    end

    // read data sampled in the last strobe cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readData <= 16'h0000;
        end else if (state == xmb_pkg::ST_IDLE) begin
            readData <= 16'h0000;
        end else if (state == xmb_pkg::ST_DATA && strobeCnt == 8'h00 && !cycWrite) begin
            // 8-bit width: low port byte lands in the lane picked by the lsb
            if (cfg.dataWide ? cycByteEn[0] : !cycAddr[0]) begin
                readData[7:0] <= pinIn.low;
            end
            // nibble not on the bus reads zero
            if (cfg.dataWide ? cycByteEn[1] : cycAddr[0]) begin
                readData[15:8] <= !cfg.dataWide ? pinIn.low :
                                  cfg.addrWidth == `XMB_ABW_12 ?
                                  {4'h0, pinIn.high[3:0]} : pinIn.high;
            end
        end
    end
    // core answer: one-cycle pulse, data held until next answer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rspValid <= 1'b0;
            rspError <= 1'b0;
            rspData  <= 16'h0000;
        end else begin
            rspValid <= state == xmb_pkg::ST_DONE || state == xmb_pkg::ST_FAIL;
            if (state == xmb_pkg::ST_DONE || state == xmb_pkg::ST_FAIL) begin
                rspError <= state == xmb_pkg::ST_FAIL;
                rspData  <= state == xmb_pkg::ST_DONE ? readData : 16'h0000;
            end
        end
    end

    // pin values driven by the sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busAd    <= 16'h0000;
            busAdOe  <= 16'h0000;
            busUpper <= 4'h0;
            busCtl   <= `XMB_CTL_IDLE;
        end else begin
            busCtl <= `XMB_CTL_IDLE;
            unique case (state)
                xmb_pkg::ST_ADDR, xmb_pkg::ST_LATCH: begin
                    // address out, strobe high then low before data
                    busAd                <= lineAddr[15:0];
                    busAdOe              <= 16'hffff;
                    busUpper             <= lineAddr[19:16];
                    busCtl[`XMB_CTL_ALE] <= state == xmb_pkg::ST_ADDR;
                    busCtl[`XMB_CTL_CE]  <= 1'b0;
                    busCtl[`XMB_CTL_BA0] <= cycAddr[0];
                end
                xmb_pkg::ST_DATA: begin
                    busCtl[`XMB_CTL_CE]  <= 1'b0;
                    busCtl[`XMB_CTL_BA0] <= cycAddr[0];
                    busCtl[`XMB_CTL_LB]  <= cfg.dataWide ? !cycByteEn[0] : 1'b0;
                    busCtl[`XMB_CTL_UB]  <= cfg.dataWide ? !cycByteEn[1] : 1'b0;
                    busCtl[`XMB_CTL_OE]  <= cycWrite;
                    if (cfg.dataWide) begin
                        busAd   <= cycWdata;
                        busAdOe <= {16{cycWrite}};
                        busCtl[`XMB_CTL_WRL] <= !(cycWrite && cycByteEn[0]);
                        busCtl[`XMB_CTL_WRH] <= !(cycWrite && cycByteEn[1]);
                    end else begin
                        // 8-bit: high port keeps address only
                        busAd[7:0]           <= cycAddr[0] ? cycWdata[15:8] : cycWdata[7:0];
                        busAdOe[7:0]         <= {8{cycWrite}};
                        busCtl[`XMB_CTL_WRL] <= !cycWrite;
                    end
                end
                default: begin
                    busAdOe <= 16'h0000;
                end
            endcase
        end
    end

    // ****************************************
    // pin multiplexing
    // ****************************************
    xmb_pkg::xmb_port_t busMask;
    xmb_pkg::xmb_port_t busOut;
    xmb_pkg::xmb_port_t busOe;

    // four ports, 20 address/data lines plus 8 control
    assign busMask = bus_mask(cfg, busDisable || !cfgLoaded);
    // lines 0-15 on low/high ports, 16-19 on upper port
    assign busOut  = '{ctl: busCtl, upper: {4'h0, busUpper},
                       high: busAd[15:8], low: busAd[7:0]};
    // control pins always driven while owned
    assign busOe   = '{ctl: 8'hff, upper: 8'h0f, high: busAdOe[15:8], low: busAdOe[7:0]};
    // width dependent ownership, the rest follows port registers
    assign pinOut  = (busMask & busOut) | (~busMask & portOut);
    assign pinOe   = (busMask & busOe) | (~busMask & portDir);

endmodule

// ---- verification/xmb_bus_chk.sv ----
// checker for pin timing, address and mode relations of the memory bus
`timescale 1ns/10ps
module xmb_bus_chk #(
    parameter logic [20:0] ONCHIP_BYTES = 21'h010000
) (
    input wire logic               mclk,
    input wire logic               resetn,
    input wire xmb_pkg::xmb_cfg_t  cfgWord,
    input wire logic               reqValid,
    input wire logic               reqReady,
    input wire xmb_pkg::xmb_req_t  req,
    input wire logic               rspValid,
    input wire logic               rspError,
    input wire xmb_pkg::xmb_port_t pinOut,
    input wire xmb_pkg::xmb_port_t pinOe
);
    logic [20:0] capAddr;
    logic [1:0]  capBe;
    // strobes only count while the control pin is output-enabled
    wire         aleOn = pinOe.ctl[0] && pinOut.ctl[0];
    wire         oeOn  = pinOe.ctl[1] && !pinOut.ctl[1];
    wire         strOn = pinOe.ctl[1] && !(pinOut.ctl[1] && pinOut.ctl[2] && pinOut.ctl[3]);
    wire [19:0]  expLine = capAddr[20:1] - (cfgWord.shiftEn ? ONCHIP_BYTES[20:1] : 20'h0);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ****
    // request capture, the address pins are judged against it
    // ****
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            capAddr <= 21'h000000;
            capBe <= 2'h0;
        end else if (reqValid && reqReady) begin
            capAddr <= req.addr;
            capBe <= req.byteEn;
        end
    end
    AST_ALE_QUIET: assert property ($rose(aleOn) |-> pinOut.ctl[3:1] == 3'h7 && pinOe.low == 8'hff)
        else $error("strobe active during address phase");
    AST_ADDR_HELD: assert property ($fell(aleOn) |-> $stable(pinOut.low) && $stable(pinOut.high))
        else $error("address not held at latch fall");
    AST_STROBE_SOON: assert property ($fell(aleOn) |-> ##[1:4] strOn)
        else $error("no data strobe after latch fall");
    AST_READ_FREE: assert property (oeOn |-> pinOe.low == 8'h00)
        else $error("shared lines driven during read");
    AST_MCU_ERROR: assert property (rspValid && cfgWord.addrWidth == 2'h3 |-> rspError)
        else $error("bus cycle answered in controller-only mode");
    AST_MCU_QUIET: assert property (cfgWord.addrWidth == 2'h3 |-> !aleOn)
        else $error("latch strobe in controller-only mode");
    AST_FREED_PINS: assert property (aleOn && cfgWord.addrWidth inside {2'h1, 2'h2}
        |-> $stable(pinOut.upper) && $stable(pinOe.upper))
        else $error("freed upper pins disturbed by a bus cycle");
    AST_WIDE_ADDR: assert property ($rose(aleOn) && cfgWord.addrWidth == 2'h0
        |-> {pinOut.upper[3:0], pinOut.high, pinOut.low} == expLine && pinOe.upper[3:0] == 4'hf)
        else $error("wrong address on the bus");
    AST_BYTE_PAIR: assert property (strOn && cfgWord.dataWide && capBe == 2'h3 && !pinOut.ctl[2]
        |-> !pinOut.ctl[3] && pinOut.ctl[7:6] == 2'h0)
        else $error("word write without both byte strobes");
    AST_BA0_HIGH: assert property (strOn && !cfgWord.dataWide && capBe == 2'h2 |-> pinOut.ctl[4])
        else $error("upper byte access with byte address low");
endmodule
bind xmb_external_memory_bus xmb_bus_chk #(.ONCHIP_BYTES(ONCHIP_BYTES)) chk_u (
    .mclk(mclk), .resetn(resetn), .cfgWord(cfgWord), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rspValid(rspValid), .rspError(rspError), .pinOut(pinOut), .pinOe(pinOe));

// ---- verification/xmb_mem_model.sv ----
// model of the external parallel memory behind an address latch
`timescale 1ns/10ps
module xmb_mem_model (
    input  wire logic               mclk,
    input  wire xmb_pkg::xmb_port_t pinOut,
    input  wire xmb_pkg::xmb_port_t pinOe,
    input  wire logic               dataWide,
    output xmb_pkg::xmb_port_t      pinIn
);
    logic [15:0] mem [0:4095];
    logic [19:0] lat = 20'h00000;
    logic [15:0] last = 16'h0000;
    logic [15:0] word;
    wire         ale = pinOe.ctl[0] && pinOut.ctl[0];
    wire         rd  = pinOe.ctl[1] && !pinOut.ctl[1];
    wire         wr  = pinOe.ctl[2] && (!pinOut.ctl[2] || !pinOut.ctl[3]);
    wire         ba0 = pinOut.ctl[4];
    // only twelve line bits index the array, so tests keep them distinct
    assign word = mem[lat[11:0]];
    initial for (int i = 0; i < 4096; i++) mem[i] = 16'h0000;
    always @(negedge ale) lat <= {pinOut.upper[3:0], pinOut.high, pinOut.low};
    always @(posedge mclk) begin
        if (dataWide && wr && !pinOut.ctl[2]) mem[lat[11:0]][7:0] <= pinOut.low;
        if (dataWide && wr && !pinOut.ctl[3]) mem[lat[11:0]][15:8] <= pinOut.high;
        if (!dataWide && wr && ba0) mem[lat[11:0]][15:8] <= pinOut.low;
        if (!dataWide && wr && !ba0) mem[lat[11:0]][7:0] <= pinOut.low;
        if (rd) last <= {pinIn.high, pinIn.low};
    end
    // released lines show the inverse of the last value, never a stale copy
    always_comb begin
        pinIn.ctl = 8'h00;
        pinIn.upper = 8'h00;
        {pinIn.high, pinIn.low} = ~last;
        if (rd && dataWide) {pinIn.high, pinIn.low} = word;
        if (rd && !dataWide) pinIn.low = ba0 ? word[15:8] : word[7:0];
    end
endmodule

// ---- verification/xmb_external_memory_bus_tb.sv ----
// self-checking bench for the external memory bus
`timescale 1ns/10ps
module xmb_external_memory_bus_tb;
    typedef struct packed {
        logic [3:0]  cfg;
        logic        wr;
        logic [20:0] addr;
        logic [15:0] wd;
        logic [1:0]  be;
        logic        err;
        logic [15:0] rd;
    } xmb_row_t;
    localparam logic [20:0] ADR = 21'h012344;
    // cfg is {dataWide, addrWidth, shiftEn}
    xmb_row_t rows [9] = '{
        '{4'h8, 1'b1, ADR, 16'hbeef, 2'h3, 1'b0, 16'h0000},
        '{4'h8, 1'b0, ADR, 16'h0000, 2'h3, 1'b0, 16'hbeef},
        '{4'h0, 1'b0, ADR, 16'h0000, 2'h3, 1'b0, 16'hbeef},
        '{4'h0, 1'b1, ADR, 16'h5a00, 2'h2, 1'b0, 16'h0000},
        '{4'h8, 1'b0, ADR, 16'h0000, 2'h3, 1'b0, 16'h5aef},
        '{4'hc, 1'b0, ADR, 16'h0000, 2'h3, 1'b0, 16'h0aef},
        '{4'ha, 1'b0, ADR, 16'h0000, 2'h3, 1'b0, 16'h5aef},
        '{4'h9, 1'b0, 21'h022344, 16'h0000, 2'h3, 1'b0, 16'h5aef},
        '{4'he, 1'b0, ADR, 16'h0000, 2'h3, 1'b1, 16'h0000}};
    logic               mclk = 1'b0;
    logic               resetn = 1'b0;
    xmb_pkg::xmb_cfg_t  cfgWord = 4'h8;
    logic               reqValid = 1'b0;
    xmb_pkg::xmb_req_t  req = '0;
    logic               reqReady, rspValid, rspError, err;
    logic [15:0]        rspData, dat;
    xmb_pkg::xmb_port_t pinIn, pinOut, pinOe;
    logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]        s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]         s_axi_wstrb = 4'hf;
    logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic               s_axi_arvalid = 0, s_axi_rready = 0;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
    int                 bad_count = 0, check_count = 0;
    xmb_external_memory_bus dut_u (.mclk, .resetn, .cfgWord, .reqValid, .reqReady, .req,
        .rspValid, .rspError, .rspData, .pinIn, .pinOut, .pinOe, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    xmb_mem_model mem_u (.mclk, .pinOut, .pinOe, .dataWide(cfgWord.dataWide), .pinIn);
    always #4 mclk = ~mclk;
    // ****
    // shared tasks: compare, reset, register bus, core request
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic doReset(input logic [3:0] c);
        @(posedge mclk);
        resetn <= 1'b0;
        cfgWord <= c;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask
    // handshakes sampled mid-cycle, where they hold their edge value
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, got;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            got = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!got);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [7:0] a);
        logic ta, got;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!got);
        s_axi_rready <= 1'b0;
    endtask
    task automatic doReq(input logic w, input logic [20:0] a, input logic [15:0] d,
                         input logic [1:0] be);
        logic ta, got;
        @(posedge mclk);
        reqValid <= 1'b1;
        req <= '{w, a, d, be};
        do begin
            @(negedge mclk);
            ta = reqValid && reqReady;
            got = rspValid;
            err = rspError;
            dat = rspData;
            @(posedge mclk);
            if (ta) reqValid <= 1'b0;
        end while (!got);
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // main sequence: table of widths and modes, then hand-written cases
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        axiRd(8'h04);
        check(rd, 32'h0);
        for (int i = 0; i < 9; i++) begin
            doReset(rows[i].cfg);
            doReq(rows[i].wr, rows[i].addr, rows[i].wd, rows[i].be);
            check(err, rows[i].err);
            check(dat, rows[i].rd);
        end
        axiRd(8'h00);
        check(rd, 32'he);
        axiWr(8'h00, 32'h1);
        check(resp, 2'h0);
        axiRd(8'h00);
        check(rd, 32'he);
        axiRd(8'h3c);
        check(resp, 2'h3);
        axiWr(8'h10, 32'h00ff00ff);
        axiWr(8'h0c, 32'h00a5005a);
        @(negedge mclk);
        check(pinOe, 32'h00ff00ff);
        check(pinOut, 32'h00a5005a);
        doReset(4'ha);
        axiWr(8'h10, 32'h000f0000);
        axiWr(8'h0c, 32'h00050000);
        axiWr(8'h04, 32'h1);
        doReq(1'b0, ADR, 16'h0, 2'h3);
        check(err, 1'b1);
        check(pinOut.upper[3:0], 4'h5);
        check(pinOe.upper[3:0], 4'hf);
        axiWr(8'h04, 32'h0);
        doReq(1'b1, ADR + 21'h2, 16'h1234, 2'h3);
        doReq(1'b0, ADR + 21'h2, 16'h0, 2'h3);
        check(dat, 16'h1234);
        check(pinOut.upper[3:0], 4'h5);
        wrap_up;
    end
    // watchdog at 12500 cycles, well beyond the expected few hundred cycles
    initial begin
        #100000;
        bad_count++;
        wrap_up;
    end
endmodule
